//--- shared/apr_consts.vh
// constants for the audio post-processing parameter register bank
`ifndef APR_CONSTS_VH
`define APR_CONSTS_VH

// register indices as printed; byte address is four times the index
`define APR_IDX_FLOW        12'h122
`define APR_IDX_BEEP        12'h123
`define APR_IDX_SUBLP       12'h124
`define APR_IDX_DELAY       12'h126
`define APR_IDX_STATUS      12'h128

// reset values
`define APR_RST_FLOW        16'h8001
`define APR_RST_BEEP        16'h0005
`define APR_RST_SUBLP       16'h0003
`define APR_RST_DELAY       16'h0000

// writable bit masks (reserved bits held at their fixed value)
`define APR_MASK_FLOW       16'h7FFF
`define APR_MASK_BEEP       16'h0F3F
`define APR_MASK_SUBLP      16'h000F
`define APR_MASK_DELAY      16'h0FFF

// field positions
`define APR_FLOW_SPAT       0
`define APR_FLOW_BEEPONLY   1
`define APR_FLOW_LOUD       2
`define APR_BEEP_VOL_LSB    8
`define APR_BEEP_VOL_MSB    11
`define APR_BEEP_FRQ_LSB    0
`define APR_BEEP_FRQ_MSB    5
`define APR_SUB_LSB         0
`define APR_SUB_MSB         3
`define APR_DLY_LSB         0
`define APR_DLY_MSB         11

// highest legal delay code
`define APR_DLY_MAX         12'h7E1

// axi answers
`define APR_RESP_OKAY       2'h0
`define APR_RESP_SLVERR     2'h2

`endif

//--- verification/apr_param_checker.sv
// concurrent checks on the audio parameter register bank ports
`timescale 1ns/1ns
module apr_param_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        sample_tick,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        headphone_one_loudness_en,
  input wire        headphone_one_beeper_only,
  input wire        headphone_one_mix_programme,
  input wire        spatializer_en,
  input wire [3:0]  beeper_volume_code,
  input wire        beeper_on,
  input wire [5:0]  beeper_freq_code,
  input wire [3:0]  subwoofer_cutoff_code,
  input wire        subwoofer_lpf_on,
  input wire [11:0] resampler_delay_code,
  input wire [12:0] resampler_delay_samples
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mix_inverse: assert property (headphone_one_mix_programme != headphone_one_beeper_only)
    else $error("programme mix not inverse of beeper only");
  a_beep_active: assert property (beeper_on == (beeper_volume_code != 4'h0 && beeper_freq_code != 6'h00))
    else $error("beeper on flag wrong");
  a_lpf_active: assert property (subwoofer_lpf_on == (subwoofer_cutoff_code != 4'h0))
    else $error("subwoofer filter flag wrong");
  a_delay_plus_one: assert property (resampler_delay_samples == {1'b0, resampler_delay_code} + 13'h0001)
    else $error("delay samples not code plus one");
  // outputs may only move at a sample strobe, so audio never sees a half-written set
  a_hold_no_tick: assert property (!sample_tick |=> $stable({
    headphone_one_loudness_en, headphone_one_beeper_only, spatializer_en,
    beeper_volume_code, beeper_freq_code, subwoofer_cutoff_code, resampler_delay_code}))
    else $error("audio output changed without sample strobe");
  a_reset_values: assert property (disable iff (1'b0) !aresetn |=> spatializer_en && !headphone_one_loudness_en
    && !headphone_one_beeper_only && beeper_volume_code == 4'h0 && beeper_freq_code == 6'h05
    && subwoofer_cutoff_code == 4'h3 && resampler_delay_code == 12'h000)
    else $error("output not at reset value");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  c_tick_beep_only: cover property (sample_tick && headphone_one_beeper_only);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule // apr_param_checker

bind apr_param_regs apr_param_checker u_chk (.aclk(aclk), .aresetn(aresetn), .sample_tick(sample_tick),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .headphone_one_loudness_en(headphone_one_loudness_en),
  .headphone_one_beeper_only(headphone_one_beeper_only), .headphone_one_mix_programme(headphone_one_mix_programme),
  .spatializer_en(spatializer_en), .beeper_volume_code(beeper_volume_code), .beeper_on(beeper_on),
  .beeper_freq_code(beeper_freq_code), .subwoofer_cutoff_code(subwoofer_cutoff_code),
  .subwoofer_lpf_on(subwoofer_lpf_on), .resampler_delay_code(resampler_delay_code),
  .resampler_delay_samples(resampler_delay_samples));

//--- verification/test_apr_param_regs.sv
// self-checking bench for the audio parameter register bank
`timescale 1ns/1ns
`include "apr_consts.vh"
module test_apr_param_regs;
  localparam [13:0] A_FLOW = {`APR_IDX_FLOW, 2'b00};
  localparam [13:0] A_BEEP = {`APR_IDX_BEEP, 2'b00};
  localparam [13:0] A_SUB  = {`APR_IDX_SUBLP, 2'b00};
  localparam [13:0] A_DLY  = {`APR_IDX_DELAY, 2'b00};
  localparam [13:0] A_STAT = {`APR_IDX_STATUS, 2'b00};
  reg         aclk = 1'b0, aresetn = 1'b0, sample_tick = 1'b0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [13:0] awaddr = 14'h0000, araddr = 14'h0000;
  reg  [31:0] wdata = 32'h00000000;
  reg  [3:0]  strb = 4'hF;
  wire        awready, wready, bvalid, arready, rvalid, loud, bonly, mix, spat, bon, lpfon;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  vol, cut;
  wire [5:0]  frq;
  wire [11:0] dcode;
  wire [12:0] dsamp;
  integer     err_total = 0, n_compared = 0, i, v;
  always #25 aclk = ~aclk;
  apr_param_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_tick(sample_tick), .headphone_one_loudness_en(loud),
    .headphone_one_beeper_only(bonly), .headphone_one_mix_programme(mix), .spatializer_en(spat),
    .beeper_volume_code(vol), .beeper_on(bon), .beeper_freq_code(frq), .subwoofer_cutoff_code(cut),
    .subwoofer_lpf_on(lpfon), .resampler_delay_code(dcode), .resampler_delay_samples(dsamp));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [13:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        n = n + 1;
      end while (!bvalid && n < 100);
      bready <= 1'b0;
      chk("bvalid", bvalid, 1'b1);
      chk("bresp", bresp, er);
    end
  endtask
  task rd(input [13:0] a, input [31:0] ed, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        n = n + 1;
      end while (!rvalid && n < 100);
      rready <= 1'b0;
      chk("rvalid", rvalid, 1'b1);
      chk("rdata", rdata, ed);
      chk("rresp", rresp, er);
    end
  endtask
  // settle point is the falling edge so shadow updates have landed
  task tick;
    begin
      @(posedge aclk) sample_tick <= 1'b1;
      @(posedge aclk) sample_tick <= 1'b0;
      @(negedge aclk);
    end
  endtask
  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("spat", spat, 1);
    chk("beep", {vol, 2'b00, frq}, 16'h0005);
    chk("sub", cut, 3);
    chk("dsamp", dsamp, 1);
    rd(A_FLOW, 32'h8001, `APR_RESP_OKAY);
    rd(A_BEEP, 32'h0005, `APR_RESP_OKAY);
    rd(A_SUB, 32'h0003, `APR_RESP_OKAY);
    rd(A_DLY, 32'h0000, `APR_RESP_OKAY);
    $display("reset values test done");
    wr(A_FLOW, 32'h8006, `APR_RESP_OKAY);
    rd(A_FLOW, 32'h8006, `APR_RESP_OKAY);
    chk("spat held", spat, 1);
    tick;
    chk("flow out", {loud, bonly, mix, spat}, 4'b1100);
    wr(A_FLOW, 32'h8001, `APR_RESP_OKAY);
    tick;
    chk("flow out", {loud, bonly, mix, spat}, 4'b0011);
    $display("flow switch test done");
    for (i = 0; i < 4; i = i + 1) begin
      v = {i[1] ? 4'hF : 4'h0, 2'b00, i[0] ? 6'h3F : 6'h00};
      wr(A_BEEP, v, `APR_RESP_OKAY);
      rd(A_BEEP, v, `APR_RESP_OKAY);
      tick;
      chk("beep out", {bon, vol, frq}, {i == 3, v[11:8], v[5:0]});
    end
    for (i = 0; i < 16; i = i + 5) begin
      wr(A_SUB, i, `APR_RESP_OKAY);
      tick;
      chk("sub out", {lpfon, cut}, {i != 0, i[3:0]});
    end
    for (i = 0; i < 2; i = i + 1) begin
      v = i ? 12'h7E1 : 12'h000;
      wr(A_DLY, v, `APR_RESP_OKAY);
      tick;
      chk("delay out", {dsamp, dcode}, {v[12:0] + 13'h0001, v[11:0]});
    end
    // status: pending set by a write, cleared once a sample strobe has passed
    wr(A_DLY, 32'h0000, `APR_RESP_OKAY);
    rd(A_STAT, 32'h0001, `APR_RESP_OKAY);
    chk("delay held", dsamp, 13'h07E2);
    tick;
    rd(A_STAT, 32'h0000, `APR_RESP_OKAY);
    chk("delay out", dsamp, 1);
    // low byte lane only: volume field keeps its old value
    strb <= 4'h1;
    wr(A_BEEP, 32'h0A07, `APR_RESP_OKAY);
    strb <= 4'hF;
    rd(A_BEEP, 32'h0F07, `APR_RESP_OKAY);
    $display("parameter field test done");
    wr({12'h125, 2'b00}, 32'h0001, `APR_RESP_SLVERR);
    rd({12'h125, 2'b00}, 32'h0000, `APR_RESP_SLVERR);
    $display("unmapped access test done");
    summarize;
  end
endmodule // test_apr_param_regs

//--- verilog/apr_param_regs.v
// axi4-lite register bank holding the audio post-processing parameters
`timescale 1ns/1ns
`include "apr_consts.vh"

// Overview of operation
// [RULE1] flow bit 2 enables headphone one loudness
// [RULE2] flow bit 1 set: beeper only
// [RULE3] flow bit 1 clear: programme plus beeper
// [RULE4] flow bit 0 spatializer enable, resets one
// [RULE5] beeper register resets to 0x0005
// [RULE6] beeper volume: zero off, -38..-10 dB
// [RULE7] beeper frequency code times 187.5 Hz
// [RULE8] software writes reserved bits as zero
// [RULE9] subwoofer register resets to 0x0003, 100 Hz
// [RULE10] subwoofer cutoff: zero off, 60..340 Hz
// [RULE11] delay is code plus one samples
// [RULE12] software keeps delay code at most 0x7E1
// [RULE13] delay register resets to zero
// [RULE14] flow resets 0x8001, bit 15 one
// [RULE15] new value active by next sample
module apr_param_regs #(
  parameter ADDR_W = 14
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              sample_tick,
  output wire              headphone_one_loudness_en,
  output wire              headphone_one_beeper_only,
  output wire              headphone_one_mix_programme,
  output wire              spatializer_en,
  output wire [3:0]        beeper_volume_code,
  output wire              beeper_on,
  output wire [5:0]        beeper_freq_code,
  output wire [3:0]        subwoofer_cutoff_code,
  output wire              subwoofer_lpf_on,
  output wire [11:0]       resampler_delay_code,
  output wire [12:0]       resampler_delay_samples
);

  reg  [15:0]       flow;
  reg  [15:0]       beep;
  reg  [15:0]       sublp;
  reg  [15:0]       dly;
  reg               aw_held;
  reg  [ADDR_W-1:0] aw_addr;
  reg               w_held;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;
  reg               dly_over;
  reg               pending;
  wire [15:0]       act_flow;
  wire [15:0]       act_beep;
  wire [15:0]       act_sublp;
  wire [15:0]       act_dly;
  wire              do_write;
  wire [11:0]       w_idx;
  wire [11:0]       r_idx;
  wire [15:0]       w_half;
  wire [15:0]       w_lanes;
  reg               w_hit;
  reg  [31:0]       next_rdata;
  reg               r_hit;

  // each write channel is taken into its own holding register, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign w_idx         = aw_addr[13:2];
  assign r_idx         = s_axi_araddr[13:2];
  assign w_half        = w_data[15:0];
  assign w_lanes       = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always @* begin
    case (w_idx)
      `APR_IDX_FLOW:  w_hit = 1'b1;
      `APR_IDX_BEEP:  w_hit = 1'b1;
      `APR_IDX_SUBLP: w_hit = 1'b1;
      `APR_IDX_DELAY: w_hit = 1'b1;
      default:        w_hit = 1'b0;
    endcase
  end

  // reserved bits are not stored, so a careless write cannot upset the flow
  always @(posedge aclk) begin
    if (!aresetn) begin
      flow     <= `APR_RST_FLOW;  // [RULE14] [RULE4]
      beep     <= `APR_RST_BEEP;  // [RULE5]
      sublp    <= `APR_RST_SUBLP; // [RULE9]
      dly      <= `APR_RST_DELAY; // [RULE13]
      dly_over <= 1'b0;
    end else if (do_write) begin
      case (w_idx)
        `APR_IDX_FLOW: begin
          flow <= (((flow & ~w_lanes) | (w_half & w_lanes)) & `APR_MASK_FLOW) | ~`APR_MASK_FLOW; // [RULE14]
        end
        `APR_IDX_BEEP: begin
          beep <= ((beep & ~w_lanes) | (w_half & w_lanes)) & `APR_MASK_BEEP; // [RULE8]
        end
        `APR_IDX_SUBLP: begin
          sublp <= ((sublp & ~w_lanes) | (w_half & w_lanes)) & `APR_MASK_SUBLP; // [RULE8]
        end
        `APR_IDX_DELAY: begin
          dly <= ((dly & ~w_lanes) | (w_half & w_lanes)) & `APR_MASK_DELAY; // [RULE8]
          // out-of-range codes are stored as written but flagged in status
          dly_over <= ((((dly & ~w_lanes) | (w_half & w_lanes)) & `APR_MASK_DELAY) > {4'h0, `APR_DLY_MAX}); // [RULE12]
        end
        default: begin
          flow <= flow;
        end
      endcase
    end
  end

  // write response follows both halves of the write
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `APR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= w_hit ? `APR_RESP_OKAY : `APR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // pending: a mapped register was written since the last sample boundary
  always @(posedge aclk) begin
    if (!aresetn) begin
      pending <= 1'b0;
    end else if (do_write && w_hit) begin
      pending <= 1'b1;
    end else if (sample_tick) begin
      pending <= 1'b0;
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    r_hit      = 1'b1;
    case (r_idx)
      `APR_IDX_FLOW:   next_rdata = {16'h0000, flow};
      `APR_IDX_BEEP:   next_rdata = {16'h0000, beep};
      `APR_IDX_SUBLP:  next_rdata = {16'h0000, sublp};
      `APR_IDX_DELAY:  next_rdata = {16'h0000, dly};
      `APR_IDX_STATUS: next_rdata = {30'h0000_0000, dly_over, pending};
      default:         r_hit      = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `APR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= r_hit ? `APR_RESP_OKAY : `APR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // one shadow stage per register; all move together at the sample strobe
  apr_shadow #(.WIDTH(16), .RST(`APR_RST_FLOW)) u_sh_flow (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sample_tick (sample_tick),
    .live        (flow),
    .active      (act_flow)
  ); // [RULE15]
  apr_shadow #(.WIDTH(16), .RST(`APR_RST_BEEP)) u_sh_beep (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sample_tick (sample_tick),
    .live        (beep),
    .active      (act_beep)
  ); // [RULE15]
  apr_shadow #(.WIDTH(16), .RST(`APR_RST_SUBLP)) u_sh_sublp (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sample_tick (sample_tick),
    .live        (sublp),
    .active      (act_sublp)
  ); // [RULE15]
  apr_shadow #(.WIDTH(16), .RST(`APR_RST_DELAY)) u_sh_dly (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sample_tick (sample_tick),
    .live        (dly),
    .active      (act_dly)
  ); // [RULE15]

  assign headphone_one_loudness_en   = act_flow[`APR_FLOW_LOUD];      // [RULE1]
  assign headphone_one_beeper_only   = act_flow[`APR_FLOW_BEEPONLY];  // [RULE2]
  assign headphone_one_mix_programme = !act_flow[`APR_FLOW_BEEPONLY]; // [RULE3]
  assign spatializer_en              = act_flow[`APR_FLOW_SPAT];      // [RULE4]

  // volume code n>0 means -40+2n dB; code zero silences the tone
  assign beeper_volume_code = act_beep[`APR_BEEP_VOL_MSB:`APR_BEEP_VOL_LSB];            // [RULE6]
  // frequency code n means n*187.5 Hz; code zero stops the tone
  assign beeper_freq_code   = act_beep[`APR_BEEP_FRQ_MSB:`APR_BEEP_FRQ_LSB];            // [RULE7]
  assign beeper_on          = (beeper_volume_code != 4'h0) && (beeper_freq_code != 6'h00); // [RULE6] [RULE7]

  // cutoff code n>0 means 40+20n Hz; code zero turns the filter off
  assign subwoofer_cutoff_code = act_sublp[`APR_SUB_MSB:`APR_SUB_LSB]; // [RULE10]
  assign subwoofer_lpf_on      = (subwoofer_cutoff_code != 4'h0);     // [RULE10]

  // each sample step is one 20.83 us period at 48 kHz
  assign resampler_delay_code    = act_dly[`APR_DLY_MSB:`APR_DLY_LSB];     // [RULE11]
  assign resampler_delay_samples = {1'b0, resampler_delay_code} + 13'h0001; // [RULE11]

endmodule // apr_param_regs

//--- verilog/apr_shadow.v
// shadow register that moves a parameter onto the audio path at a sample strobe
`timescale 1ns/1ns
module apr_shadow #(
  parameter WIDTH            = 16,
  parameter [WIDTH-1:0] RST  = {WIDTH{1'b0}}
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             sample_tick,
  input  wire [WIDTH-1:0] live,
  output reg  [WIDTH-1:0] active
);

  // updating only at a sample boundary keeps one sample from seeing half a change
  always @(posedge aclk) begin
    if (!aresetn) begin
      active <= RST;
    end else if (sample_tick) begin
      active <= live;
    end
  end

endmodule // apr_shadow
